// *** verilog/homing_sequence_control.v ***
// Homing sequencer: picks and runs the search phases of methods 1 to 9.
//
// Behaviour
// - Method 1, negative limit low: fast negative to rise, slow back to fall.
// - Method 1, negative limit high: slow positive, stop at its fall.
// - Method 2, positive limit low: fast positive to rise, slow back to fall.
// - Method 2, positive limit high: slow negative, stop at its fall.
// - Method 3, home low: fast positive to rise, slow back to fall.
// - Method 3, home high: slow negative, stop at home fall.
// - Method 4, home low: slow positive, stop at home rise.
// - Method 4, home high: fast negative to fall, slow back to rise.
// - Method 5, home high: slow positive, stop at index after home fall.
// - Method 5, home low: fast negative to rise, slow back, index after fall.
// - Method 6, home high: fast positive to fall, slow back, index after rise.
// - Method 6, home low: slow positive, stop at index after home rise.
// - Method 7, home low: fast positive to rise, slow back to fall.
// - Method 7, home high: slow negative, stop at home fall.
// - Method 7, limit hit: fast negative, slow at rise, stop at fall.
// - Method 8, home low: fast positive, slow at home rise, stop at index.
// - Method 8, home high: slow negative to fall, slow positive to index.
// - Method 8, limit hit: fast negative, slow to fall, positive to index.
// - Method 9, home low: fast positive, slow after rise, back to index.
// - Method 9, home high: slow positive to fall, slow negative to index.
// - Method 9, limit hit: fast negative to rise, slow negative to index.
// - Methods 5, 6, 8 and 9: the first index pulse in the final phase marks home.
`timescale 1ns/100ps
`include "homing_defs.vh"
module homing_sequence_control (
    input  wire       core_clk_i,    // System clock, 50 MHz.
    input  wire       rst_i,         // Asynchronous reset, active high.
    input  wire       home_enable_i, // Homing mode enable, level.
    input  wire [3:0] method_i,      // Homing method, 1 to 9.
    input  wire       neg_limit_i,   // Negative limit switch input.
    input  wire       pos_limit_i,   // Positive limit switch input.
    input  wire       home_sw_i,     // Reference (home) switch input.
    input  wire       index_i,       // Encoder once-per-turn index.
    output reg        move_o,        // Motion command, zero speed when low.
    output reg        fast_o,        // Speed select: 1 fast, 0 slow.
    output reg        dir_o,         // Direction: 1 positive, 0 negative.
    output reg        busy_o,        // Sequence running.
    output reg        done_o,        // Sequence completed, home found.
    output reg        fault_o        // Unsupported method selected.
);

    ////////////////////////////////////////////////////////////////////////
    // State encoding.

    localparam [4:0] ST_IDLE  = 5'h01;
    localparam [4:0] ST_START = 5'h02;
    localparam [4:0] ST_RUN   = 5'h04;
    localparam [4:0] ST_DONE  = 5'h08;
    localparam [4:0] ST_FAULT = 5'h10;

    ////////////////////////////////////////////////////////////////////////
    // Input conditioning.

    wire nlim_lvl;
    wire nlim_rise;
    wire nlim_fall;
    wire plim_lvl;
    wire plim_rise;
    wire plim_fall;
    wire home_lvl;
    wire home_rise;
    wire home_fall;
    wire idx_rise;

    input_edge_sync u_nlim (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .raw_i      (neg_limit_i),
        .level_o    (nlim_lvl),
        .rise_o     (nlim_rise),
        .fall_o     (nlim_fall)
    );

    input_edge_sync u_plim (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .raw_i      (pos_limit_i),
        .level_o    (plim_lvl),
        .rise_o     (plim_rise),
        .fall_o     (plim_fall)
    );

    input_edge_sync u_home (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .raw_i      (home_sw_i),
        .level_o    (home_lvl),
        .rise_o     (home_rise),
        .fall_o     (home_fall)
    );

    // The index is a short marker; only its leading edge is used.
    input_edge_sync u_index (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .raw_i      (index_i),
        .level_o    (),
        .rise_o     (idx_rise),
        .fall_o     ()
    );

    ////////////////////////////////////////////////////////////////////////
    // Phase table: {last, dir, fast, stop event} per method, variant, phase.

    function [`DESC_W-1:0] phase_desc;
        input [3:0] m;
        input [1:0] v;
        input [1:0] p;
        begin
            case ({m, v, p})
                {4'h1, `VAR_LO, 2'h0}:
                    phase_desc = {`PH_MORE, `DIR_NEG, `SPD_FAST, `EV_NLIM_RISE};
                {4'h1, `VAR_LO, 2'h1}:
                    phase_desc = {`PH_LAST, `DIR_POS, `SPD_SLOW, `EV_NLIM_FALL};
                {4'h1, `VAR_HI, 2'h0}:
                    phase_desc = {`PH_LAST, `DIR_POS, `SPD_SLOW, `EV_NLIM_FALL};
                {4'h2, `VAR_LO, 2'h0}:
                    phase_desc = {`PH_MORE, `DIR_POS, `SPD_FAST, `EV_PLIM_RISE};
                {4'h2, `VAR_LO, 2'h1}:
                    phase_desc = {`PH_LAST, `DIR_NEG, `SPD_SLOW, `EV_PLIM_FALL};
                {4'h2, `VAR_HI, 2'h0}:
                    phase_desc = {`PH_LAST, `DIR_NEG, `SPD_SLOW, `EV_PLIM_FALL};
                {4'h3, `VAR_LO, 2'h0}:
                    phase_desc = {`PH_MORE, `DIR_POS, `SPD_FAST, `EV_HOME_RISE};
                {4'h3, `VAR_LO, 2'h1}:
                    phase_desc = {`PH_LAST, `DIR_NEG, `SPD_SLOW, `EV_HOME_FALL};
                {4'h3, `VAR_HI, 2'h0}:
                    phase_desc = {`PH_LAST, `DIR_NEG, `SPD_SLOW, `EV_HOME_FALL};
                {4'h4, `VAR_LO, 2'h0}:
                    phase_desc = {`PH_LAST, `DIR_POS, `SPD_SLOW, `EV_HOME_RISE};
                {4'h4, `VAR_HI, 2'h0}:
                    phase_desc = {`PH_MORE, `DIR_NEG, `SPD_FAST, `EV_HOME_FALL};
                {4'h4, `VAR_HI, 2'h1}:
                    phase_desc = {`PH_LAST, `DIR_POS, `SPD_SLOW, `EV_HOME_RISE};
                {4'h5, `VAR_HI, 2'h0}:
                    phase_desc = {`PH_MORE, `DIR_POS, `SPD_SLOW, `EV_HOME_FALL};
                {4'h5, `VAR_HI, 2'h1}:
                    phase_desc = {`PH_LAST, `DIR_POS, `SPD_SLOW, `EV_INDEX};
                {4'h5, `VAR_LO, 2'h0}:
                    phase_desc = {`PH_MORE, `DIR_NEG, `SPD_FAST, `EV_HOME_RISE};
                {4'h5, `VAR_LO, 2'h1}:
                    phase_desc = {`PH_MORE, `DIR_POS, `SPD_SLOW, `EV_HOME_FALL};
                {4'h5, `VAR_LO, 2'h2}:
                    phase_desc = {`PH_LAST, `DIR_POS, `SPD_SLOW, `EV_INDEX};
                {4'h6, `VAR_HI, 2'h0}:
                    phase_desc = {`PH_MORE, `DIR_POS, `SPD_FAST, `EV_HOME_FALL};
                {4'h6, `VAR_HI, 2'h1}:
                    phase_desc = {`PH_MORE, `DIR_NEG, `SPD_SLOW, `EV_HOME_RISE};
                {4'h6, `VAR_HI, 2'h2}:
                    phase_desc = {`PH_LAST, `DIR_NEG, `SPD_SLOW, `EV_INDEX};
                {4'h6, `VAR_LO, 2'h0}:
                    phase_desc = {`PH_MORE, `DIR_POS, `SPD_SLOW, `EV_HOME_RISE};
                {4'h6, `VAR_LO, 2'h1}:
                    phase_desc = {`PH_LAST, `DIR_POS, `SPD_SLOW, `EV_INDEX};
                {4'h7, `VAR_LO, 2'h0}:
                    phase_desc = {`PH_MORE, `DIR_POS, `SPD_FAST, `EV_HOME_RISE};
                {4'h7, `VAR_LO, 2'h1}:
                    phase_desc = {`PH_LAST, `DIR_NEG, `SPD_SLOW, `EV_HOME_FALL};
                {4'h7, `VAR_HI, 2'h0}:
                    phase_desc = {`PH_LAST, `DIR_NEG, `SPD_SLOW, `EV_HOME_FALL};
                {4'h7, `VAR_LIM, 2'h0}:
                    phase_desc = {`PH_MORE, `DIR_NEG, `SPD_FAST, `EV_HOME_RISE};
                {4'h7, `VAR_LIM, 2'h1}:
                    phase_desc = {`PH_LAST, `DIR_NEG, `SPD_SLOW, `EV_HOME_FALL};
                {4'h8, `VAR_LO, 2'h0}:
                    phase_desc = {`PH_MORE, `DIR_POS, `SPD_FAST, `EV_HOME_RISE};
                {4'h8, `VAR_LO, 2'h1}:
                    phase_desc = {`PH_LAST, `DIR_POS, `SPD_SLOW, `EV_INDEX};
                {4'h8, `VAR_HI, 2'h0}:
                    phase_desc = {`PH_MORE, `DIR_NEG, `SPD_SLOW, `EV_HOME_FALL};
                {4'h8, `VAR_HI, 2'h1}:
                    phase_desc = {`PH_MORE, `DIR_POS, `SPD_SLOW, `EV_HOME_RISE};
                {4'h8, `VAR_HI, 2'h2}:
                    phase_desc = {`PH_LAST, `DIR_POS, `SPD_SLOW, `EV_INDEX};
                {4'h8, `VAR_LIM, 2'h0}:
                    phase_desc = {`PH_MORE, `DIR_NEG, `SPD_FAST, `EV_HOME_RISE};
                {4'h8, `VAR_LIM, 2'h1}:
                    phase_desc = {`PH_MORE, `DIR_NEG, `SPD_SLOW, `EV_HOME_FALL};
                {4'h8, `VAR_LIM, 2'h2}:
                    phase_desc = {`PH_LAST, `DIR_POS, `SPD_SLOW, `EV_INDEX};
                {4'h9, `VAR_LO, 2'h0}:
                    phase_desc = {`PH_MORE, `DIR_POS, `SPD_FAST, `EV_HOME_RISE};
                {4'h9, `VAR_LO, 2'h1}:
                    phase_desc = {`PH_MORE, `DIR_POS, `SPD_SLOW, `EV_HOME_FALL};
                {4'h9, `VAR_LO, 2'h2}:
                    phase_desc = {`PH_LAST, `DIR_NEG, `SPD_SLOW, `EV_INDEX};
                {4'h9, `VAR_HI, 2'h0}:
                    phase_desc = {`PH_MORE, `DIR_POS, `SPD_SLOW, `EV_HOME_FALL};
                {4'h9, `VAR_HI, 2'h1}:
                    phase_desc = {`PH_LAST, `DIR_NEG, `SPD_SLOW, `EV_INDEX};
                {4'h9, `VAR_LIM, 2'h0}:
                    phase_desc = {`PH_MORE, `DIR_NEG, `SPD_FAST, `EV_HOME_RISE};
                {4'h9, `VAR_LIM, 2'h1}:
                    phase_desc = {`PH_LAST, `DIR_NEG, `SPD_SLOW, `EV_INDEX};
                default:
                    phase_desc = {`PH_LAST, `DIR_NEG, `SPD_SLOW, `EV_NONE};
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state.

    reg [4:0] state_r;
    reg [4:0] state_nxt;
    reg [3:0] method_r;
    reg [3:0] method_nxt;
    reg [1:0] var_r;
    reg [1:0] var_nxt;
    reg [1:0] phase_r;
    reg [1:0] phase_nxt;
    reg       start_lvl;
    reg       ev_hit;
    reg       lim_hit;

    wire [`DESC_W-1:0] desc = phase_desc(method_r, var_r, phase_r);
    wire [2:0]         desc_ev = desc[`DESC_EV_MSB:`DESC_EV_LSB];
    wire               method_ok = (method_i >= `METHOD_MIN) &&
                                   (method_i <= `METHOD_MAX);

    always @* begin
        // Methods 1 and 2 key on their limit; the rest on the home switch.
        case (method_i)
            `METHOD_NLIM: start_lvl = nlim_lvl;
            `METHOD_PLIM: start_lvl = plim_lvl;
            default:      start_lvl = home_lvl;
        endcase
        case (desc_ev)
            `EV_NLIM_RISE: ev_hit = nlim_rise;
            `EV_NLIM_FALL: ev_hit = nlim_fall;
            `EV_PLIM_RISE: ev_hit = plim_rise;
            `EV_PLIM_FALL: ev_hit = plim_fall;
            `EV_HOME_RISE: ev_hit = home_rise;
            `EV_HOME_FALL: ev_hit = home_fall;
            `EV_INDEX:     ev_hit = idx_rise;
            default:       ev_hit = 1'b0;
        endcase
        // Only the first fast positive search of methods 7 to 9 reacts
        // to the positive limit; it then restarts in the recovery table.
        lim_hit = plim_rise && (method_r >= `METHOD_LIMSRCH) &&
                  (var_r == `VAR_LO) && (phase_r == 2'h0);
    end

    always @* begin
        state_nxt  = state_r;
        method_nxt = method_r;
        var_nxt    = var_r;
        phase_nxt  = phase_r;
        case (state_r)
            ST_IDLE: begin
                if (home_enable_i) begin
                    state_nxt = ST_START;
                end
            end
            ST_START: begin
                method_nxt = method_i;
                phase_nxt  = 2'h0;
                var_nxt    = start_lvl ? `VAR_HI : `VAR_LO;
                if (!home_enable_i) begin
                    state_nxt = ST_IDLE;
                end else if (method_ok) begin
                    state_nxt = ST_RUN;
                end else begin
                    state_nxt = ST_FAULT;
                end
            end
            ST_RUN: begin
                if (!home_enable_i) begin
                    state_nxt = ST_IDLE;
                end else if (lim_hit) begin
                    var_nxt   = `VAR_LIM;
                    phase_nxt = 2'h0;
                end else if (ev_hit) begin
                    if (desc[`DESC_LAST_BIT]) begin
                        state_nxt = ST_DONE;
                    end else begin
                        phase_nxt = phase_r + 2'h1;
                    end
                end
            end
            ST_DONE, ST_FAULT: begin
                // A new run needs homing mode to be dropped and re-enabled.
                if (!home_enable_i) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r  <= ST_IDLE;
            method_r <= 4'h0;
            var_r    <= `VAR_LO;
            phase_r  <= 2'h0;
        end else begin
            state_r  <= state_nxt;
            method_r <= method_nxt;
            var_r    <= var_nxt;
            phase_r  <= phase_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered command outputs, one cycle behind the sequencer state.

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            move_o  <= 1'b0;
            fast_o  <= `RST_FAST;
            dir_o   <= `RST_DIR;
            busy_o  <= 1'b0;
            done_o  <= 1'b0;
            fault_o <= 1'b0;
        end else begin
            move_o  <= (state_r == ST_RUN);
            fast_o  <= (state_r == ST_RUN) && desc[`DESC_FAST_BIT];
            dir_o   <= desc[`DESC_DIR_BIT];
            busy_o  <= (state_r == ST_START) || (state_r == ST_RUN);
            done_o  <= (state_r == ST_DONE);
            fault_o <= (state_r == ST_FAULT);
        end
    end

endmodule

// *** verilog/homing_defs.vh ***
// Shared constants for the homing sequencer: events, phase fields, methods.
`ifndef HOMING_DEFS_VH
`define HOMING_DEFS_VH

// Stop events a phase can wait for.
`define EV_NLIM_RISE   3'h0
`define EV_NLIM_FALL   3'h1
`define EV_PLIM_RISE   3'h2
`define EV_PLIM_FALL   3'h3
`define EV_HOME_RISE   3'h4
`define EV_HOME_FALL   3'h5
`define EV_INDEX       3'h6
`define EV_NONE        3'h7

// Phase descriptor fields: {last, dir, fast, event[2:0]}.
`define DESC_W         6
`define DESC_LAST_BIT  5
`define DESC_DIR_BIT   4
`define DESC_FAST_BIT  3
`define DESC_EV_MSB    2
`define DESC_EV_LSB    0

`define PH_LAST        1'b1
`define PH_MORE        1'b0
`define DIR_POS        1'b1
`define DIR_NEG        1'b0
`define SPD_FAST       1'b1
`define SPD_SLOW       1'b0

// Start variants: start level low, start level high, limit-hit recovery.
`define VAR_LO         2'h0
`define VAR_HI         2'h1
`define VAR_LIM        2'h2

// Supported method numbers.
`define METHOD_NLIM    4'h1
`define METHOD_PLIM    4'h2
`define METHOD_MIN     4'h1
`define METHOD_MAX     4'h9
`define METHOD_LIMSRCH 4'h7

// Reset values of the motion command.
`define RST_DIR        1'b0
`define RST_FAST       1'b0

`endif

// *** verilog/input_edge_sync.v ***
// Two-stage input synchroniser with level and edge pulse outputs.
`timescale 1ns/100ps
module input_edge_sync (
    input  wire core_clk_i,   // System clock.
    input  wire rst_i,        // Asynchronous reset, active high.
    input  wire raw_i,        // Raw switch or index input.
    output wire level_o,      // Synchronised level.
    output wire rise_o,       // One-cycle pulse on a rising edge.
    output wire fall_o        // One-cycle pulse on a falling edge.
);

    reg meta_r;
    reg sync_r;
    reg prev_r;

    // The first stage feeds only the second, so metastability stays
    // out of the edge detector.
    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= raw_i;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level_o = sync_r;
    assign rise_o  = sync_r & ~prev_r;
    assign fall_o  = ~sync_r & prev_r;

endmodule

// *** testbench/homing_sequence_control_assertions.sv ***
// Concurrent checks on the ports of the homing sequencer.
`timescale 1ns/100ps
module homing_checker (
    input wire       core_clk_i,    // System clock.
    input wire       rst_i,         // Asynchronous reset, active high.
    input wire       home_enable_i, // Homing enable.
    input wire [3:0] method_i,      // Homing method.
    input wire       neg_limit_i,   // Negative limit switch.
    input wire       pos_limit_i,   // Positive limit switch.
    input wire       home_sw_i,     // Home switch.
    input wire       index_i,       // Encoder index.
    input wire       move_o,        // Motion command.
    input wire       fast_o,        // Speed select.
    input wire       dir_o,         // Direction.
    input wire       busy_o,        // Sequence running.
    input wire       done_o,        // Sequence completed.
    input wire       fault_o        // Unsupported method.
);
    wire idle = !busy_o && !done_o && !fault_o;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    AST_DISABLED_STOPS: assert property (
        !home_enable_i [*3] |-> !move_o && !busy_o)
        else $error("Motion commanded while homing is disabled.");
    AST_SLOW_AT_REST: assert property (!move_o |-> !fast_o)
        else $error("Fast selected with zero speed.");
    AST_MOVE_BUSY: assert property (move_o |-> busy_o && !done_o)
        else $error("Motion outside a running sequence.");
    AST_DONE_AT_REST: assert property (
        done_o |-> !move_o && !busy_o && !fault_o)
        else $error("Done flagged while still moving.");
    // A one-cycle drop of enable legally ends the hold, hence the $past.
    AST_DONE_HOLDS: assert property (
        done_o && home_enable_i && $past(home_enable_i) |=> done_o)
        else $error("Done dropped while enable is high.");
    AST_START_LATENCY: assert property (
        $rose(home_enable_i) && idle |-> ##2 (busy_o || fault_o))
        else $error("Sequence did not start two cycles after enable.");
    // Commands trail the state register by one edge, so a start or a
    // refusal shows three edges after enable is first seen.
    AST_BAD_METHOD: assert property (
        $rose(home_enable_i) && idle ##1
        home_enable_i && (method_i == 4'h0 || method_i > 4'h9)
        |-> ##2 fault_o && !move_o)
        else $error("Unsupported method not refused.");
    AST_FAULT_HOLDS: assert property (
        fault_o && home_enable_i && $past(home_enable_i)
        |=> fault_o && !move_o)
        else $error("Fault dropped or motion began.");
    AST_M1_HIGH_START: assert property (
        $rose(home_enable_i) && idle && neg_limit_i && $stable(neg_limit_i)
        ##1 home_enable_i && method_i == 4'h1
        |-> ##2 move_o && dir_o && !fast_o)
        else $error("Method 1 high start is not slow positive.");
    AST_M2_LOW_START: assert property (
        $rose(home_enable_i) && idle && !pos_limit_i && $stable(pos_limit_i)
        ##1 home_enable_i && method_i == 4'h2
        |-> ##2 move_o && dir_o && fast_o)
        else $error("Method 2 low start is not fast positive.");
endmodule

bind homing_sequence_control homing_checker chk (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .home_enable_i(home_enable_i), .method_i(method_i),
    .neg_limit_i(neg_limit_i), .pos_limit_i(pos_limit_i),
    .home_sw_i(home_sw_i), .index_i(index_i), .move_o(move_o),
    .fast_o(fast_o), .dir_o(dir_o), .busy_o(busy_o), .done_o(done_o),
    .fault_o(fault_o));

// *** testbench/axis_model.sv ***
// Axis model: a carriage with limit, home and index sensors.
`timescale 1ns/100ps
module axis_model (
    input  wire core_clk_i, // System clock.
    input  wire move_i,     // Motion command.
    input  wire fast_i,     // Speed select.
    input  wire dir_i,      // Direction, 1 positive.
    output wire neg_lim_o,  // Negative limit switch.
    output wire pos_lim_o,  // Positive limit switch.
    output wire home_o,     // Home switch.
    output wire index_o     // Encoder index, once per 16 units.
);
    integer pos = 0;
    // Fast steps are four units, slow steps one, so a slow phase sees
    // every index mark as a one-cycle pulse.
    always @(posedge core_clk_i) begin
        if (move_i) begin
            pos <= pos + (dir_i ? 1 : -1) * (fast_i ? 4 : 1);
        end
    end
    assign neg_lim_o = (pos <= 0);
    assign pos_lim_o = (pos >= 1000);
    assign home_o    = (pos >= 500) && (pos <= 600);
    assign index_o   = (pos % 16 == 0);
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the homing sequencer against an axis model.
`timescale 1ns/100ps
module tb;
    localparam [2:0] FP = 3'h7;
    localparam [2:0] FN = 3'h5;
    localparam [2:0] SP = 3'h6;
    localparam [2:0] SN = 3'h4;
    reg         core_clk_i    = 1'b0;
    reg         rst_i         = 1'b1;
    reg         home_enable_i = 1'b0;
    reg  [3:0]  method_i      = 4'h0;
    wire        neg_limit_i;
    wire        pos_limit_i;
    wire        home_sw_i;
    wire        index_i;
    wire        move_o;
    wire        fast_o;
    wire        dir_o;
    wire        busy_o;
    wire        done_o;
    wire        fault_o;
    integer     fails         = 0;
    integer     total_checks  = 0;
    integer     seed          = 32'hD013;
    integer     i;
    reg  [11:0] seq;
    reg  [2:0]  last;

    always #10 core_clk_i = ~core_clk_i;

    homing_sequence_control DUT (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .home_enable_i(home_enable_i), .method_i(method_i),
        .neg_limit_i(neg_limit_i), .pos_limit_i(pos_limit_i),
        .home_sw_i(home_sw_i), .index_i(index_i), .move_o(move_o),
        .fast_o(fast_o), .dir_o(dir_o), .busy_o(busy_o), .done_o(done_o),
        .fault_o(fault_o));
    axis_model ax (.core_clk_i(core_clk_i), .move_i(move_o),
        .fast_i(fast_o), .dir_i(dir_o), .neg_lim_o(neg_limit_i),
        .pos_lim_o(pos_limit_i), .home_o(home_sw_i), .index_o(index_i));

    ////////////////////////////////////////////////////////////////////////
    // Phases are packed three bits each, oldest first, as the run logs them.
    function [11:0] pk(input [2:0] a, input [2:0] b, input [2:0] c,
                       input [2:0] d);
        pk = {a, b, c, d};
    endfunction

    task check(input [11:0] seen, input [11:0] want);
        begin
            total_checks = total_checks + 1;
            if (seen !== want) begin
                fails = fails + 1;
                $display("Error at %0t: seen %h expected %h", $time, seen,
                         want);
            end
        end
    endtask

    task close_out;
        begin
            $display("Checks %0d, mismatches %0d", total_checks, fails);
            if (fails == 0 && total_checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    // A random offset below 16 keeps every start inside its switch zone.
    task run_one(input [3:0] m, input integer start, input [11:0] want);
        integer n;
        begin
            ax.pos = start + ($random(seed) & 15);
            method_i = m;
            repeat (4) @(negedge core_clk_i);
            home_enable_i = 1'b1;
            seq = 12'h000;
            last = 3'h0;
            for (n = 0; n < 1000 && done_o !== 1'b1; n = n + 1) begin
                @(negedge core_clk_i);
                if (move_o === 1'b1 && {1'b1, dir_o, fast_o} !== last) begin
                    last = {1'b1, dir_o, fast_o};
                    seq = {seq[8:0], last};
                end
            end
            check(seq, want);
            check({done_o, fault_o, move_o}, 12'h4);
            home_enable_i = 1'b0;
            repeat (3) @(negedge core_clk_i);
            check({done_o, busy_o}, 12'h0);
            $display("Test method %0d from %0d finished", m, start);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #600000;
        fails = fails + 1;
        close_out;
    end

    initial begin
        repeat (2) @(negedge core_clk_i);
        rst_i = 1'b0;
        run_one(4'h1, 100, pk(0, 0, FN, SP));
        run_one(4'h1, -20, pk(0, 0, 0, SP));
        run_one(4'h2, 900, pk(0, 0, FP, SN));
        run_one(4'h2, 1020, pk(0, 0, 0, SN));
        run_one(4'h3, 300, pk(0, 0, FP, SN));
        run_one(4'h3, 550, pk(0, 0, 0, SN));
        run_one(4'h4, 300, pk(0, 0, 0, SP));
        run_one(4'h4, 550, pk(0, 0, FN, SP));
        run_one(4'h5, 550, pk(0, 0, 0, SP));
        run_one(4'h5, 700, pk(0, 0, FN, SP));
        run_one(4'h6, 550, pk(0, 0, FP, SN));
        run_one(4'h6, 300, pk(0, 0, 0, SP));
        run_one(4'h7, 300, pk(0, 0, FP, SN));
        run_one(4'h7, 550, pk(0, 0, 0, SN));
        run_one(4'h7, 700, pk(0, FP, FN, SN));
        run_one(4'h8, 300, pk(0, 0, FP, SP));
        run_one(4'h8, 550, pk(0, 0, SN, SP));
        run_one(4'h8, 700, pk(FP, FN, SN, SP));
        run_one(4'h9, 300, pk(0, FP, SP, SN));
        run_one(4'h9, 550, pk(0, 0, SP, SN));
        run_one(4'h9, 700, pk(0, FP, FN, SN));
        for (i = 0; i < 6; i = i + 1) begin
            method_i = (i == 0) ? 4'h0 : (i == 1) ? 4'hA : (i == 2) ? 4'hF
                     : 4'h1 + ($random(seed) & 7);
            ax.pos = 300;
            repeat (4) @(negedge core_clk_i);
            home_enable_i = 1'b1;
            repeat (3 + (i < 3 ? 0 : ($random(seed) & 31)))
                @(negedge core_clk_i);
            if (i < 3)
                check({fault_o, move_o, busy_o}, 12'h4);
            home_enable_i = 1'b0;
            repeat (3) @(negedge core_clk_i);
            check({move_o, fast_o, busy_o, fault_o}, 12'h0);
            $display("Test stop case %0d finished", i);
        end
        close_out;
    end
endmodule
